// >>> hdl/tcp_divided_freq_output_div.sv
// oscillator prescaler and frequency output divider
`timescale 1ns/1ps
module tcp_dfo_div (
  // clock and control
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic hold,
  // events from the pins
  input wire logic [4:0] src_rise,
  input wire logic [4:0] gate_rise,
  // divider setup
  input wire logic [3:0] dfo_src,
  input wire logic [3:0] dfo_ratio,
  input wire logic dfo_off,
  // outputs
  output logic [4:0] freq_ev,
  output logic divided_freq_output
);

  logic [15:0] presc_r;   // oscillator prescaler
  logic [3:0] div_r;      // divider position
  logic [3:0] div_nxt;
  logic [4:0] ratio;      // zero ratio stands for sixteen
  logic [4:0] half;
  logic ev;

  // scaled frequencies: osc, /16, /256, /4096, /65536
  assign freq_ev = {&presc_r[15:0], &presc_r[11:0], &presc_r[7:0],
                    &presc_r[3:0], 1'b1};

  // prescaler runs freely once out of power-on reset
  always_ff @(posedge core_clk) begin
    if (reset || hold) begin
      presc_r <= 16'h0000;
    end else if (ce) begin
      presc_r <= presc_r + 16'h0001;
    end
  end

  assign ratio = {dfo_ratio == 4'h0, dfo_ratio};
  assign half = 5'((ratio + 5'h01) >> 1);
  assign ev = tcp_pkg::pick_event(dfo_src, src_rise, gate_rise,
                                  freq_ev);

  // next divider position on each selected input event
  always_comb begin
    div_nxt = div_r;
    if (ev) begin
      div_nxt = ({1'b0, div_r} + 5'h01 >= ratio) ? 4'h0 : div_r + 4'h1;
    end
  end

  // divider and output level, held low when switched off
  always_ff @(posedge core_clk) begin
    if (reset || hold) begin
      div_r <= 4'hf; // last position, first event starts a full high half
      divided_freq_output <= 1'b0;
    end else if (ce) begin
      div_r <= div_nxt;
      if (dfo_off) begin
        divided_freq_output <= 1'b0;
      end else if (ratio == 5'h01) begin
        divided_freq_output <= ev;
      end else begin
        divided_freq_output <= ({1'b0, div_nxt} < half);
      end
    end
  end

endmodule

// >>> hdl/tcp_pkg.sv
// shared constants, field layouts and helpers for the timing controller
package tcp_pkg;

  // five counters, two of them with an alarm compare
  localparam int NUM_CNT = 5;
  localparam int NUM_ALARM = 2;

  // command byte layout: top three bits select the command family
  localparam logic [2:0] CMD_FAM_PTR = 3'h0;    // low five bits: pointer
  localparam logic [2:0] CMD_FAM_ARM = 3'h1;    // low five bits: counters
  localparam logic [2:0] CMD_FAM_DISARM = 3'h2; // low five bits: counters
  localparam logic [2:0] CMD_FAM_LOAD = 3'h3;   // low five bits: counters
  localparam logic [7:0] CMD_BUS16 = 8'hef;     // widen the host bus
  localparam logic [7:0] CMD_BUS8 = 8'he7;      // back to the narrow bus
  localparam logic [7:0] CMD_SOFT_RESET = 8'hff;

  // data pointer targets
  localparam logic [4:0] IDX_MASTER = 5'h00;
  localparam logic [4:0] IDX_MODE0 = 5'h01;
  localparam logic [4:0] IDX_LOAD0 = 5'h06;
  localparam logic [4:0] IDX_ALARM0 = 5'h0b;
  localparam logic [4:0] IDX_COUNT0 = 5'h0d;

  // reset values
  localparam logic [15:0] MMODE_RST = 16'h00b0;  // first scaled freq, /16
  localparam logic [15:0] CMODE_RST = 16'h6000;  // output floated
  localparam logic [15:0] LOAD_RST = 16'h0000;
  localparam logic [15:0] ALARM_RST = 16'h0000;
  localparam logic [15:0] MMODE_USED = 16'hf0ff; // spare bits read zero

  // fifteen selectable count sources, code zero picks the oscillator
  localparam logic [3:0] SRC_PIN0 = 4'h1;
  localparam logic [3:0] SRC_GATE0 = 4'h6;
  localparam logic [3:0] SRC_FREQ0 = 4'hb;

  // gating modes
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_LEVEL = 2'h1;
  localparam logic [1:0] GATE_EDGE = 2'h2;
  localparam logic [1:0] GATE_SELECT = 2'h3;

  // output waveform modes
  localparam logic [1:0] OUT_PULSE = 2'h0;
  localparam logic [1:0] OUT_SQUARE = 2'h1;
  localparam logic [1:0] OUT_DUTY = 2'h2;
  localparam logic [1:0] OUT_FLOAT = 2'h3;

  // counter limits
  localparam logic [15:0] BIN_MAX = 16'hffff;
  localparam logic [15:0] BCD_MAX = 16'h9999;

  // per-counter mode register
  typedef struct packed {
    logic out_low;          // output active low
    logic [1:0] out_mode;   // waveform kind
    logic bcd;              // decimal coding
    logic down;             // count direction
    logic [2:0] gate_sel;   // which gate pin
    logic gate_low;         // gate active low
    logic [1:0] gate_mode;  // gating kind
    logic src_fall;         // count on falling source edge
    logic [3:0] src_sel;    // count source code
  } tcp_cmode_s;

  // master mode register
  typedef struct packed {
    logic [1:0] alarm_en;   // alarm compare for counters 1 and 2
    logic bus16;            // host bus width
    logic dfo_off;          // frequency output gated off
    logic [3:0] spare;      // unused
    logic [3:0] dfo_src;    // divider source code
    logic [3:0] dfo_ratio;  // divide ratio, zero means 16
  } tcp_mmode_s;

  // pick one event out of the fifteen sources
  function automatic logic pick_event(input logic [3:0] code,
                                      input logic [4:0] src_ev,
                                      input logic [4:0] gate_ev,
                                      input logic [4:0] freq_ev);
    logic r;
    r = freq_ev[0];
    if (code >= SRC_FREQ0) begin
      r = freq_ev[3'(code - SRC_FREQ0)];
    end else if (code >= SRC_GATE0) begin
      r = gate_ev[3'(code - SRC_GATE0)];
    end else if (code >= SRC_PIN0) begin
      r = src_ev[3'(code - SRC_PIN0)];
    end
    return r;
  endfunction

  // one decimal step up or down over four digits
  function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                           input logic dn);
    logic [15:0] r;
    logic carry;
    logic [3:0] d;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = v[i*4 +: 4];
      if (carry) begin
        if (dn) begin
          carry = (d == 4'h0);
          d = carry ? 4'h9 : d - 4'h1;
        end else begin
          carry = (d == 4'h9);
          d = carry ? 4'h0 : d + 4'h1;
        end
      end
      r[i*4 +: 4] = d;
    end
    return r;
  endfunction

endpackage

// >>> hdl/tcp_top.sv
// timing controller: host bus port, five counters and frequency output
// Contract
// - output divider ratio one to sixteen
// - divider source picked from fifteen inputs
// - output switchable, held low when off
// - power-up output: first scaled freq over sixteen
// - gate pins enable counting, shareable
// - gate pins usable as count sources
// - per-counter gate polarity, level/edge/none
// - gate level selects between two frequencies
// - source pins routable, per-counter polarity
// - three-state outputs, waveform and polarity
// - terminal count drives output waveform
// - alarm compare overrides counters 1, 2
// - bus direction follows strobes and select
// - bus starts eight bits wide
// - widen bus by command, lines 13-15 high
// - upper lines never driven in 8-bit mode
// - lines 8-12 act as auxiliary gates in 8-bit mode
// - strobes ignored without chip select
// - first chip select clears power-on reset
// - control access: command/pointer, status read
// - five 16-bit up/down binary/decimal counters
`timescale 1ns/1ps
module tcp_top (
  // clock, reset, clock enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // host bus
  input wire logic [15:0] host_bus_in,
  output logic [15:0] host_bus_out,
  output logic [15:0] host_bus_oe_n,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic ctl_data,
  // counter pins
  input wire logic [4:0] counter_gate_inputs,
  input wire logic [4:0] count_source_inputs,
  output logic [4:0] counter_output_pins,
  output logic [4:0] counter_output_oe_n,
  // frequency output
  output logic divided_freq_output
);

  localparam int N = tcp_pkg::NUM_CNT;

  // host-side registers
  logic por_r;                 // power-on reset pending
  logic wr_q_r;                // previous write strobe
  logic rd_q_r;                // previous read strobe
  logic [4:0] ptr_r;           // data pointer
  logic byte_hi_r;             // next byte is the high one
  logic [7:0] lo_hold_r;       // held low byte of a data write
  logic [15:0] mmode_r;        // master mode
  logic [15:0] mode_r [N];     // counter modes
  logic [15:0] load_r [N];     // reload values
  logic [15:0] alarm_r [tcp_pkg::NUM_ALARM]; // alarm compares
  logic [N-1:0] armed_r;       // counters allowed to run
  logic [N-1:0] load_go_r;     // one-cycle count load request
  logic [15:0] count_r [N];    // counter contents
  logic [N-1:0] out_lvl;       // output level before polarity
  logic [4:0] src_q_r;         // previous source pins
  logic [4:0] gate_q_r;        // previous gate pins

  // decoded strobes
  logic cs;
  logic wr_act;
  logic rd_act;
  logic wr_take;
  logic rd_done;
  logic live;
  logic [7:0] cmd;
  logic [15:0] wdata;
  logic wcommit;
  logic [15:0] rd_word;
  logic [4:0] src_rise;
  logic [4:0] src_fall;
  logic [4:0] gate_rise;
  tcp_pkg::tcp_mmode_s mm;
  logic [4:0] freq_ev; // scaled oscillator events

  assign mm = tcp_pkg::tcp_mmode_s'(mmode_r);

  // strobes only count while chip select is low
  assign cs = ~chip_sel_n;
  assign wr_act = cs & ~write_n;
  assign rd_act = cs & ~read_n;
  assign wr_take = wr_act & ~wr_q_r;
  assign rd_done = rd_q_r & ~rd_act;
  assign live = ~por_r | cs;
  assign cmd = host_bus_in[7:0];

  // source and gate edges, pins already synchronous
  assign src_rise = count_source_inputs & ~src_q_r;
  assign src_fall = ~count_source_inputs & src_q_r;
  assign gate_rise = counter_gate_inputs & ~gate_q_r;

  // pin history and strobe history
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_q_r <= 5'h00;
      gate_q_r <= 5'h00;
      wr_q_r <= 1'b0;
      rd_q_r <= 1'b0;
    end else if (ce) begin
      src_q_r <= count_source_inputs;
      gate_q_r <= counter_gate_inputs;
      wr_q_r <= wr_act;
      rd_q_r <= rd_act;
    end
  end

  // power-on reset stays until chip select is first seen
  always_ff @(posedge core_clk) begin
    if (reset) begin
      por_r <= 1'b1;
    end else if (ce && cs) begin
      por_r <= 1'b0;
    end
  end

  // assemble a data word: whole in wide mode, low then high byte narrow
  always_comb begin
    wcommit = 1'b0;
    wdata = host_bus_in;
    if (wr_take && !ctl_data) begin
      if (mm.bus16) begin
        wcommit = 1'b1;
      end else if (byte_hi_r) begin
        wcommit = 1'b1;
        wdata = {host_bus_in[7:0], lo_hold_r};
      end
    end
  end

  // command, pointer and register writes
  always_ff @(posedge core_clk) begin
    if (reset || (por_r && !cs) ||
        (ce && wr_take && ctl_data && cmd == tcp_pkg::CMD_SOFT_RESET)) begin
      ptr_r <= tcp_pkg::IDX_MASTER;
      byte_hi_r <= 1'b0;
      lo_hold_r <= 8'h00;
      mmode_r <= tcp_pkg::MMODE_RST;
      armed_r <= '0;
      load_go_r <= '0;
      for (int i = 0; i < N; i++) begin
        mode_r[i] <= tcp_pkg::CMODE_RST;
        load_r[i] <= tcp_pkg::LOAD_RST;
      end
      for (int j = 0; j < tcp_pkg::NUM_ALARM; j++) begin
        alarm_r[j] <= tcp_pkg::ALARM_RST;
      end
    end else if (ce) begin
      load_go_r <= '0;
      if (wr_take && ctl_data) begin
        // control write: command register and data pointer
        case (cmd[7:5])
          tcp_pkg::CMD_FAM_PTR: begin
            ptr_r <= cmd[4:0];
            byte_hi_r <= 1'b0;
          end
          tcp_pkg::CMD_FAM_ARM: armed_r <= armed_r | cmd[4:0];
          tcp_pkg::CMD_FAM_DISARM: armed_r <= armed_r & ~cmd[4:0];
          tcp_pkg::CMD_FAM_LOAD: load_go_r <= cmd[4:0];
          default: begin
            // widening needs lines 13 to 15 held high
            if (cmd == tcp_pkg::CMD_BUS16 && &host_bus_in[15:13]) begin
              mmode_r[13] <= 1'b1;
            end else if (cmd == tcp_pkg::CMD_BUS8) begin
              mmode_r[13] <= 1'b0;
            end
          end
        endcase
      end else if (wr_take && !mm.bus16) begin
        // narrow data write toggles the byte half
        byte_hi_r <= ~byte_hi_r;
        lo_hold_r <= host_bus_in[7:0];
      end else if (rd_done && !ctl_data && !mm.bus16) begin
        byte_hi_r <= ~byte_hi_r;
      end
      if (wcommit) begin
        // indirect target through the data pointer
        if (ptr_r == tcp_pkg::IDX_MASTER) begin
          mmode_r <= wdata & tcp_pkg::MMODE_USED;
        end
        for (int i = 0; i < N; i++) begin
          if (ptr_r == tcp_pkg::IDX_MODE0 + 5'(i)) begin
            mode_r[i] <= wdata;
          end
          if (ptr_r == tcp_pkg::IDX_LOAD0 + 5'(i)) begin
            load_r[i] <= wdata;
          end
        end
        for (int j = 0; j < tcp_pkg::NUM_ALARM; j++) begin
          if (ptr_r == tcp_pkg::IDX_ALARM0 + 5'(j)) begin
            alarm_r[j] <= wdata;
          end
        end
      end
    end
  end

  // read source: status on control, pointed register on data
  always_comb begin
    rd_word = 16'h0000;
    if (ctl_data) begin
      rd_word = {10'h000, byte_hi_r, counter_output_pins};
    end else begin
      if (ptr_r == tcp_pkg::IDX_MASTER) begin
        rd_word = mmode_r;
      end
      for (int i = 0; i < N; i++) begin
        if (ptr_r == tcp_pkg::IDX_MODE0 + 5'(i)) begin
          rd_word = mode_r[i];
        end
        if (ptr_r == tcp_pkg::IDX_LOAD0 + 5'(i)) begin
          rd_word = load_r[i];
        end
        if (ptr_r == tcp_pkg::IDX_COUNT0 + 5'(i)) begin
          rd_word = count_r[i];
        end
      end
      for (int j = 0; j < tcp_pkg::NUM_ALARM; j++) begin
        if (ptr_r == tcp_pkg::IDX_ALARM0 + 5'(j)) begin
          rd_word = alarm_r[j];
        end
      end
    end
  end

  // bus drive: only during a selected read, upper half only when wide
  always_ff @(posedge core_clk) begin
    if (reset) begin
      host_bus_out <= 16'h0000;
      host_bus_oe_n <= 16'hffff;
    end else if (ce) begin
      if (mm.bus16) begin
        host_bus_out <= rd_word;
      end else begin
        // status is one byte, so only data reads take the high half
        host_bus_out <= {8'h00, (byte_hi_r && !ctl_data) ?
                         rd_word[15:8] : rd_word[7:0]};
      end
      if (rd_act) begin
        host_bus_oe_n <= {mm.bus16 ? 8'h00 : 8'hff, 8'h00};
      end else begin
        host_bus_oe_n <= 16'hffff;
      end
    end
  end

  // the five counters
  generate
    for (genvar i = 0; i < N; i++) begin : g_cnt
      tcp_pkg::tcp_cmode_s md;
      logic g_lvl;       // gate at its active level
      logic g_q_r;       // previous active gate level
      logic run_r;       // edge-started run in progress
      logic tog_r;       // square wave state
      logic en;
      logic act;
      logic step;
      logic tc;
      logic [15:0] reload;
      logic [15:0] nxt;

      assign md = tcp_pkg::tcp_cmode_s'(mode_r[i]);
      assign g_lvl = counter_gate_inputs[md.gate_sel > 3'h4 ? 3'h0 :
                                         md.gate_sel] ^ md.gate_low;
      // auxiliary gate lines only matter on the narrow bus
      assign act = armed_r[i] & ~por_r &
                   (mm.bus16 | host_bus_in[8 + i]);

      // counting allowed by the gating mode
      always_comb begin
        case (md.gate_mode)
          tcp_pkg::GATE_LEVEL: en = g_lvl;
          tcp_pkg::GATE_EDGE: en = run_r;
          default: en = 1'b1;
        endcase
      end

      assign step = act & en & tcp_pkg::pick_event(md.src_sel,
                     md.src_fall ? src_fall : src_rise,
                     gate_rise, freq_ev);
      // next state would be zero without the reload
      assign tc = step & (md.down ? (count_r[i] == 16'h0001) :
                  (count_r[i] == (md.bcd ? tcp_pkg::BCD_MAX :
                                           tcp_pkg::BIN_MAX)));
      assign reload = (md.gate_mode == tcp_pkg::GATE_SELECT && g_lvl) ?
                      (load_r[i] >> 1) : load_r[i];
      assign nxt = md.bcd ? tcp_pkg::bcd_step(count_r[i], md.down) :
                   md.down ? count_r[i] - 16'h0001 :
                   count_r[i] + 16'h0001;

      // counter contents and gating state
      always_ff @(posedge core_clk) begin
        if (reset) begin
          count_r[i] <= 16'h0000;
          run_r <= 1'b0;
          g_q_r <= 1'b0;
        end else if (ce) begin
          g_q_r <= g_lvl;
          if (load_go_r[i]) begin
            count_r[i] <= load_r[i];
          end else if (tc) begin
            count_r[i] <= reload;
          end else if (step) begin
            count_r[i] <= nxt;
          end
          // edge start wins over the end of a run
          if (g_lvl && !g_q_r) begin
            run_r <= 1'b1;
          end else if (tc) begin
            run_r <= 1'b0;
          end
        end
      end

      // waveform level, alarm overriding on the first two counters
      always_comb begin
        case (md.out_mode)
          tcp_pkg::OUT_PULSE: out_lvl[i] = tc;
          tcp_pkg::OUT_SQUARE: out_lvl[i] = tog_r;
          tcp_pkg::OUT_DUTY: out_lvl[i] = count_r[i] < (load_r[i] >> 1);
          default: out_lvl[i] = 1'b0;
        endcase
        if (i < tcp_pkg::NUM_ALARM && mm.alarm_en[i]) begin
          out_lvl[i] = (count_r[i] == alarm_r[i]);
        end
      end

      // output pin with polarity and three-state enable
      always_ff @(posedge core_clk) begin
        if (reset) begin
          tog_r <= 1'b0;
          counter_output_pins[i] <= 1'b0;
          counter_output_oe_n[i] <= 1'b1;
        end else if (ce) begin
          if (tc) begin
            tog_r <= ~tog_r;
          end
          counter_output_pins[i] <= out_lvl[i] ^ md.out_low;
          counter_output_oe_n[i] <= (md.out_mode == tcp_pkg::OUT_FLOAT &&
            !(i < tcp_pkg::NUM_ALARM && mm.alarm_en[i]));
        end
      end
    end
  endgenerate

  // prescaler and frequency output
  tcp_dfo_div u_dfo (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .hold(por_r & ~cs),
    .src_rise(src_rise),
    .gate_rise(gate_rise),
    .dfo_src(mm.dfo_src),
    .dfo_ratio(mm.dfo_ratio),
    .dfo_off(mm.dfo_off),
    .freq_ev(freq_ev),
    .divided_freq_output(divided_freq_output)
  );

endmodule

// >>> test/tcp_host.sv
// host processor model: strobes and the resolved data bus
`timescale 1ns/1ps
module tcp_host (
  // clock
  input wire logic core_clk,
  // device side of the bus
  input wire logic [15:0] host_bus_out,
  input wire logic [15:0] host_bus_oe_n,
  output logic [15:0] host_bus_in,
  // strobes
  output logic chip_sel_n,
  output logic read_n,
  output logic write_n,
  output logic ctl_data
);
  logic [15:0] drv = 16'hffff; // host write data
  logic hoe = 1'b0; // host drives the lines
  // idle strobes at time zero
  initial begin
    chip_sel_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    ctl_data = 1'b0;
  end
  // released lines sit at the pull-up level
  assign host_bus_in = (~host_bus_oe_n & host_bus_out) |
                       (host_bus_oe_n & (hoe ? drv : 16'hffff));
  // one write, held through the edge that takes it
  task automatic wr(input logic sel, input logic c, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    chip_sel_n = ~sel;
    write_n = 1'b0;
    ctl_data = c;
    drv = d;
    hoe = 1'b1;
    @(posedge core_clk);
    #1;
    write_n = 1'b1;
    chip_sel_n = 1'b1;
    hoe = 1'b0;
  endtask
  // one read, data taken one edge after the answer
  task automatic rd(input logic c, output logic [15:0] q);
    @(posedge core_clk);
    #1;
    chip_sel_n = 1'b0;
    read_n = 1'b0;
    ctl_data = c;
    repeat (2) @(posedge core_clk);
    q = host_bus_in;
    #1;
    read_n = 1'b1;
    chip_sel_n = 1'b1;
  endtask
endmodule

// >>> test/tcp_top_chk.sv
// port checker for the timing controller top
`timescale 1ns/1ps
module tcp_top_chk (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // host bus
  input wire logic [15:0] host_bus_in,
  input wire logic [15:0] host_bus_out,
  input wire logic [15:0] host_bus_oe_n,
  input wire logic chip_sel_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic ctl_data,
  // outputs
  input wire logic [4:0] counter_output_pins,
  input wire logic [4:0] counter_output_oe_n,
  input wire logic divided_freq_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic wr_c; // selected write strobe
  logic ctl_wr; // control write
  logic pristine_r; // no selected write since reset
  logic seen_cs_r; // power-on hold released
  logic wide_r; // bus widened by command
  logic [4:0] hi_cnt_r; // length of current high run on the output
  assign wr_c = !chip_sel_n && !write_n && ce;
  assign ctl_wr = wr_c && ctl_data;
  // untouched configuration tracking
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pristine_r <= 1'b1;
    end else if (wr_c) begin
      pristine_r <= 1'b0;
    end
  end
  // first select seen
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seen_cs_r <= 1'b0;
    end else if (!chip_sel_n && ce) begin
      seen_cs_r <= 1'b1;
    end
  end
  // bus width from the widen, narrow and soft reset commands only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wide_r <= 1'b0;
    end else if (ctl_wr && host_bus_in[7:0] == tcp_pkg::CMD_BUS16 &&
                 &host_bus_in[15:13]) begin
      wide_r <= 1'b1;
    end else if (ctl_wr && (host_bus_in[7:0] == tcp_pkg::CMD_BUS8 ||
                 host_bus_in[7:0] == tcp_pkg::CMD_SOFT_RESET)) begin
      wide_r <= 1'b0;
    end
  end
  // high run length of the frequency output
  always_ff @(posedge core_clk) begin
    if (reset || !divided_freq_output) begin
      hi_cnt_r <= 5'h00;
    end else begin
      hi_cnt_r <= hi_cnt_r + 5'h01;
    end
  end
  a_cs_ignored: assert property ($past(chip_sel_n) |-> &host_bus_oe_n)
    else $error("bus driven without select");
  a_rd_drives: assert property (
    $past(!chip_sel_n && !read_n && ce) && !$past(reset)
    |-> host_bus_oe_n[7:0] == 8'h00) else $error("read not driven");
  a_idle_floats: assert property ($past(read_n) |-> &host_bus_oe_n)
    else $error("bus driven without read");
  a_upper_narrow: assert property (
    !wide_r && !$past(wide_r) |-> &host_bus_oe_n[15:8])
    else $error("upper lines driven narrow");
  a_upper_wide: assert property (
    wide_r && $past(wide_r && !chip_sel_n && !read_n && ce)
    |-> host_bus_oe_n == 16'h0000) else $error("wide read not driven");
  a_status_read: assert property (
    $past(!chip_sel_n && !read_n && ctl_data && ce) && !$past(reset)
    |-> host_bus_out[4:0] == $past(counter_output_pins))
    else $error("status pins wrong");
  a_dfo_reset: assert property (
    $fell(divided_freq_output) && pristine_r |-> hi_cnt_r == 5'h08)
    else $error("reset output high run wrong");
  a_hold_dfo: assert property (!seen_cs_r |-> !divided_freq_output)
    else $error("output runs before select");
  a_cnt_floated: assert property (
    pristine_r |-> &counter_output_oe_n) else $error("counter pin driven");
endmodule
bind tcp_top tcp_top_chk u_chk (.core_clk(core_clk), .reset(reset),
  .ce(ce), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
  .host_bus_oe_n(host_bus_oe_n), .chip_sel_n(chip_sel_n),
  .read_n(read_n), .write_n(write_n), .ctl_data(ctl_data),
  .counter_output_pins(counter_output_pins),
  .counter_output_oe_n(counter_output_oe_n),
  .divided_freq_output(divided_freq_output));

// >>> test/testbench.sv
// self-checking bench for the timing controller
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0; // system clock
  logic reset = 1'b1; // synchronous reset
  logic [15:0] bus_in, bus_out, bus_oe_n; // resolved host bus
  logic cs_n, rd_n, wr_n, ctl; // host strobes
  logic [4:0] gate_pins = 5'h00; // gate levels
  logic [4:0] src_pins = 5'h00; // source levels
  logic [4:0] cnt_pins, cnt_oe_n; // counter outputs
  logic dfo; // frequency output
  logic [15:0] q; // read result
  logic [1:0] ph = 2'h0; // slow wave phase
  int n_mismatch = 0;
  int checks = 0;
  int n; // counted high cycles
  // divider setups: {source, ratio} and highs expected in 240 cycles
  logic [7:0] cfg[8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h00, 8'hc1,
                         8'h11, 8'h61};
  int exp_hi[8] = '{240, 120, 160, 144, 120, 15, 60, 60};
  always #10 core_clk = ~core_clk;
  // period-four wave on source 0 and gate 0
  always @(posedge core_clk) begin
    #1;
    ph = ph + 2'h1;
    src_pins[0] = ph[1];
    gate_pins[0] = ph[1];
  end
  tcp_top DUT (.core_clk(core_clk), .reset(reset), .ce(1'b1),
    .host_bus_in(bus_in), .host_bus_out(bus_out), .host_bus_oe_n(bus_oe_n),
    .chip_sel_n(cs_n), .read_n(rd_n), .write_n(wr_n), .ctl_data(ctl),
    .counter_gate_inputs(gate_pins), .count_source_inputs(src_pins),
    .counter_output_pins(cnt_pins), .counter_output_oe_n(cnt_oe_n),
    .divided_freq_output(dfo));
  tcp_host host (.core_clk(core_clk), .host_bus_out(bus_out),
    .host_bus_oe_n(bus_oe_n), .host_bus_in(bus_in), .chip_sel_n(cs_n),
    .read_n(rd_n), .write_n(wr_n), .ctl_data(ctl));
  // compare a bus word
  task automatic cmp16(input string what, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // compare a count
  task automatic cmpn(input string what, input int e, g);
    checks++;
    if (g != e) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask
  // settle, then count highs of the output or counter 0 over 240 cycles
  task automatic count_hi(input bit pin, output int c);
    c = 0;
    repeat (20) @(posedge core_clk);
    repeat (240) begin
      @(posedge core_clk);
      c += ((pin ? cnt_pins[0] : dfo) === 1'b1);
    end
  endtask
  // narrow pointed register write, upper lines held high
  task automatic set_reg(input logic [7:0] p, lo, hi);
    host.wr(1'b1, 1'b1, {8'hff, p});
    host.wr(1'b1, 1'b0, {8'hff, lo});
    host.wr(1'b1, 1'b0, {8'hff, hi});
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (12000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
  // test sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    // power-up hold, status, reset divider
    count_hi(0, n);
    cmpn("output held", 0, n);
    cmp16("counter oe", 16'h001f, {11'h0, cnt_oe_n});
    host.rd(1'b1, q);
    cmp16("status", 16'hff00, q);
    count_hi(0, n);
    cmpn("reset rate", 120, n);
    host.wr(1'b1, 1'b1, 16'hff00);
    host.rd(1'b0, q);
    cmp16("master low", 16'hffb0, q);
    host.rd(1'b0, q);
    cmp16("master high", 16'hff00, q);
    $display("test power-up done");
    // strobes without select
    host.wr(1'b0, 1'b0, 16'hff07);
    host.wr(1'b0, 1'b0, 16'hff00);
    host.rd(1'b0, q);
    cmp16("unselected write", 16'hffb0, q);
    $display("test select done");
    // divider ratios and sources, then output off
    for (int i = 0; i < 8; i++) begin
      set_reg(8'h00, cfg[i], 8'h00);
      count_hi(0, n);
      cmpn("output highs", exp_hi[i], n);
    end
    set_reg(8'h00, 8'h03, 8'h10);
    count_hi(0, n);
    cmpn("output off", 0, n);
    $display("test divider done");
    // counter 0 down from four: one pulse every fourth cycle
    set_reg(8'h01, 8'h00, 8'h08);
    set_reg(8'h06, 8'h04, 8'h00);
    host.wr(1'b1, 1'b1, 16'hff61);
    host.wr(1'b1, 1'b1, 16'hff21);
    count_hi(1, n);
    cmpn("counter pulses", 60, n);
    cmp16("counter oe run", 16'h001e, {11'h0, cnt_oe_n});
    $display("test counter done");
    // widen refused, widen taken, soft reset
    host.wr(1'b1, 1'b1, 16'h1fef);
    host.wr(1'b1, 1'b1, 16'hff00);
    host.rd(1'b0, q);
    cmp16("refused widen", 16'hff03, q);
    host.wr(1'b1, 1'b1, 16'hffef);
    host.wr(1'b1, 1'b1, 16'h0000);
    host.rd(1'b0, q);
    cmp16("wide master", 16'h3003, q);
    host.wr(1'b1, 1'b1, 16'h00ff);
    host.rd(1'b0, q);
    cmp16("after soft reset", 16'hffb0, q);
    $display("test width done");
    stop_test();
  end
endmodule
